// [rsgt_pkg.sv]
// constants, register map and timing for the read skew gate timing block
package rsgt_pkg;

  // ****************************************
  // clock and divider
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int SUBCELL_HZ = 320_000;
  localparam int CHAR_HZ = 10_000;
  localparam int STEPS_PER_CELL = SUBCELL_HZ / CHAR_HZ;
  // fractional divider: add ACC_STEP each clock, wrap at ACC_MOD (only the 12.5 ips ratio exists)
  localparam int ACC_GCD = 80_000;
  localparam logic [10:0] ACC_STEP = 11'(SUBCELL_HZ / ACC_GCD);
  localparam logic [10:0] ACC_MOD = 11'(CLK_HZ / ACC_GCD);

  // ****************************************
  // gate counter presets and end count, gap counter top count
  // ****************************************
  localparam logic [4:0] GATE_END = 5'h10;
  localparam logic [4:0] PRESET_READ = 5'h00;
  localparam logic [4:0] PRESET_WRITE = 5'h04;
  localparam logic [4:0] PRESET_CHECK = 5'h0b;
  localparam logic [5:0] GAP_TOP = 6'h20;

  // ****************************************
  // one-shot lengths
  // ****************************************
  localparam int STROBE_NS = 2000;
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int AMP_RESET_NS = 2000;
  localparam int AMP_RESET_CYC = (AMP_RESET_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SKEW_PULSE_US = 1000;
  localparam int SKEW_PULSE_CYC = SKEW_PULSE_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int CTRL_WRITE_ARMED = 0;
  localparam int CTRL_MARGINAL = 1;
  localparam int CTRL_SECOND_XFER = 2;
  localparam int ST_GATE_FLOP = 0;
  localparam int ST_GAP_LATCH = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_SKEW_SEEN = 3;
  localparam int ST_GATE_CNT_LSB = 8;
  localparam int ST_GAP_CNT_LSB = 16;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rsgt_pkg

// [rsgt_read_skew_gate_timing.sv]
// read skew gate timing: divider, skew gate, strobe sequencer, gap detector, AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module rsgt_read_skew_gate_timing import rsgt_pkg::*; #(
  parameter int SKEW_PULSE_CYCLES = SKEW_PULSE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic combinedChannelPulse,
  output logic testPanelPulse,
  output logic dataTransferPulse,
  output logic readSampleStrobe,
  output logic skewFaultPulse,
  output logic ampResetPulse,
  output logic charRatePulse,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // how the block works
  // ****************************************
  // timing base:
  // - a fractional accumulator adds a small step
  //   every clock and wraps at a fixed modulus
  // - each wrap is one sub-cell tick, so ticks
  //   average the sub-cell rate exactly
  // - single ticks jitter by one clock, which is
  //   far below one sub-cell step
  // - a five-bit step counter splits the bit cell
  //   into its steps; its wrap is the cell rate
  // - only one divider ratio exists, so no speed
  //   selection logic is built
  //
  // input path:
  // - the nine channel pulses arrive already
  //   wire-ored on one pin, with no phase relation
  //   to our clock
  // - two flops resynchronise the pin before any
  //   logic looks at it
  // - a third flop keeps the last synced level so
  //   that only a rising edge counts as a pulse
  // - the synced level is also copied out for the
  //   service panel, three clocks behind the pin
  // - pulses must stay low for one clock between
  //   edges or the edge detector can merge them
  //
  // skew gate:
  // - the gate flop is set while idle between
  //   characters
  // - the first edge of a character clears it and
  //   loads the gate counter with a mode preset
  // - the counter then steps once per tick until
  //   it reaches its end count
  // - at the end count the gate flop sets again
  //   and the counter stops and returns to zero
  // - the preset picks the gate length: zero gives
  //   the full half cell, larger presets shorten it
  // - check mode outranks write mode when both
  //   control bits are set
  // - further edges while the gate is open are part
  //   of the same character and are ignored
  //
  // post-gate sequencer:
  // - closing the gate loads a one into the first
  //   stage of a four-stage shifter
  // - the shifter moves one stage per tick and
  //   falls empty after the fourth stage
  // - stage one drives the transfer pulse to the
  //   amplifiers for one tick
  // - entering stage two starts the read strobe
  //   one-shot, a fixed number of clocks long
  // - stage three is delay only
  // - stage four repeats the transfer pulse only
  //   when the second-transfer strap bit is set
  // - once empty the sequencer waits for the next
  //   character edge
  //
  // skew check:
  // - at strobe time the gate flop is looked at
  // - if it is clear, a late pulse reopened the
  //   gate after it had closed, so the character
  //   was skewed beyond the gate
  // - that starts a long skew one-shot and sets a
  //   sticky status bit
  // - software clears the sticky bit by writing a
  //   one; a new fault in the same clock wins
  // - the reopened gate runs its full length and
  //   the sequencer restarts when it closes
  //
  // blank detection:
  // - while the gate flop is set, the gap counter
  //   steps once per tick
  // - every character edge clears it
  // - when it reaches its top count the gap latch
  //   sets and the amplifier reset one-shot fires
  // - while the latch is set the counter is held
  //   at zero, so only one reset pulse is given
  //   per gap
  // - the next character edge frees the latch and
  //   detection can repeat in the next gap
  //
  // register bus:
  // - control word: write armed, check mode and
  //   second-transfer strap, all clear after reset
  // - status word: gate flop, gap latch, sequencer
  //   busy, sticky skew flag and both counters
  // - only byte lane zero of a write matters since
  //   every writable field sits in the low byte
  // - unmapped offsets answer with a slave error,
  //   read as zero and ignore writes
  // - one write and one read may be under way at a
  //   time; each answer comes one clock after the
  //   request is complete
  //
  // limitations:
  // - there is no hold-off after tape start; the
  //   read path above this block must mask strobes
  // - a pulse that straddles the gate end by less
  //   than the sync delay may be seen as a late
  //   pulse and flagged as skew
  // - the skew one-shot length is a parameter so
  //   that simulation can use a short pulse

  localparam int SKEW_W = $clog2(SKEW_PULSE_CYCLES + 1);
  localparam logic [6:0] STROBE_LEN = 7'(STROBE_CYC);
  localparam logic [6:0] RESET_LEN = 7'(AMP_RESET_CYC);
  localparam logic [SKEW_W-1:0] SKEW_LEN = SKEW_W'(SKEW_PULSE_CYCLES);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [10:0] acc;
    logic [4:0] cellStep;
    logic sync1;
    logic sync2;
    logic syncPrev;
    logic testPanel;
    logic gateFlop;
    logic [4:0] gateCounter;
    logic [3:0] postGateShifter;
    logic dataXfer;
    logic strobe;
    logic [6:0] strobeCnt;
    logic skewPulse;
    logic [SKEW_W-1:0] skewCnt;
    logic skewSeen;
    logic [5:0] gapCounter;
    logic gapLatch;
    logic ampReset;
    logic [6:0] resetCnt;
    logic charPulse;
    logic [2:0] ctrl;
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } rsgt_state_t;

  rsgt_state_t st_r;
  rsgt_state_t st_nxt;

  // register decode, used by both the read and the write path
  function automatic logic addrMapped(input logic [3:0] a);
    addrMapped = (a == ADDR_CTRL) || (a == ADDR_STATUS);
  endfunction : addrMapped

  function automatic logic [31:0] regRead(input rsgt_state_t s, input logic [3:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == ADDR_CTRL) begin
      v[2:0] = s.ctrl;
    end else if (a == ADDR_STATUS) begin
      v[ST_GATE_FLOP] = s.gateFlop;
      v[ST_GAP_LATCH] = s.gapLatch;
      v[ST_BUSY] = |s.postGateShifter;
      v[ST_SKEW_SEEN] = s.skewSeen;
      v[ST_GATE_CNT_LSB +: 5] = s.gateCounter;
      v[ST_GAP_CNT_LSB +: 6] = s.gapCounter;
    end
    regRead = v;
  endfunction : regRead

  // ****************************************
  // next-state logic
  // ****************************************
  logic [10:0] accSum;
  logic tick;
  logic dataEdge;
  logic writeDo;
  logic skewClr;
  logic skewEvent;

  // all behaviour in one pass; the clocked process only registers the copy
  always_comb begin
    st_nxt = st_r;
    skewClr = 1'b0;
    skewEvent = 1'b0;

    // fractional divider averages exactly 320 kHz; each tick jitters by one clock
    accSum = st_r.acc + ACC_STEP;
    tick = accSum >= ACC_MOD;
    st_nxt.acc = tick ? accSum - ACC_MOD : accSum;
    st_nxt.charPulse = 1'b0;
    if (tick) begin
      st_nxt.cellStep = st_r.cellStep + 5'h01;
      // crystal character rate feeds the writer only in check mode
      st_nxt.charPulse = st_r.ctrl[CTRL_MARGINAL] && (st_r.cellStep == 5'(STEPS_PER_CELL - 1));
    end

    // wire-ored channel pulses, two flops before use, edge from the second
    st_nxt.sync1 = combinedChannelPulse;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.syncPrev = st_r.sync2;
    st_nxt.testPanel = st_r.sync2;
    dataEdge = st_r.sync2 && !st_r.syncPrev;

    // shifter advances one stage per tick and drops out after the fourth
    if (tick && (st_r.postGateShifter != 4'h0)) begin
      st_nxt.postGateShifter = {st_r.postGateShifter[2:0], 1'b0};
    end

    // skew gate: first pulse opens it, a late pulse reopens it
    if (dataEdge && st_r.gateFlop) begin
      st_nxt.gateFlop = 1'b0;
      if (st_r.ctrl[CTRL_MARGINAL]) begin
        st_nxt.gateCounter = PRESET_CHECK;
      end else if (st_r.ctrl[CTRL_WRITE_ARMED]) begin
        st_nxt.gateCounter = PRESET_WRITE;
      end else begin
        st_nxt.gateCounter = PRESET_READ;
      end
    end else if (!st_r.gateFlop && tick) begin
      if (st_r.gateCounter == GATE_END - 5'h01) begin
        st_nxt.gateFlop = 1'b1;
        st_nxt.gateCounter = 5'h00;
        st_nxt.postGateShifter = 4'h1;
      end else begin
        st_nxt.gateCounter = st_r.gateCounter + 5'h01;
      end
    end

    // transfer pulse in the first stage, optionally again in the fourth
    st_nxt.dataXfer = st_nxt.postGateShifter[0]
      || (st_nxt.postGateShifter[3] && st_r.ctrl[CTRL_SECOND_XFER]);

    // second stage fires the strobe and inspects the gate flop
    if (tick && st_r.postGateShifter[0] && st_nxt.postGateShifter[1]) begin
      st_nxt.strobe = 1'b1;
      st_nxt.strobeCnt = STROBE_LEN;
      skewEvent = !st_nxt.gateFlop;
    end else if (st_r.strobeCnt != 7'h00) begin
      st_nxt.strobeCnt = st_r.strobeCnt - 7'h01;
      st_nxt.strobe = st_r.strobeCnt != 7'h01;
    end
    if (skewEvent) begin
      st_nxt.skewPulse = 1'b1;
      st_nxt.skewCnt = SKEW_LEN;
    end else if (st_r.skewCnt != '0) begin
      st_nxt.skewCnt = st_r.skewCnt - SKEW_W'(1);
      st_nxt.skewPulse = st_r.skewCnt != SKEW_W'(1);
    end

    // blank detection: counts between characters, any pulse restarts it
    st_nxt.ampReset = st_r.resetCnt > 7'h01;
    if (st_r.resetCnt != 7'h00) begin
      st_nxt.resetCnt = st_r.resetCnt - 7'h01;
    end
    if (dataEdge) begin
      st_nxt.gapCounter = 6'h00;
      st_nxt.gapLatch = 1'b0;
    end else if (tick) begin
      if (st_r.gapLatch) begin
        st_nxt.gapCounter = 6'h00;
      end else if (st_r.gateFlop) begin
        st_nxt.gapCounter = st_r.gapCounter + 6'h01;
        if (st_r.gapCounter == GAP_TOP - 6'h01) begin
          st_nxt.gapLatch = 1'b1;
          st_nxt.ampReset = 1'b1;
          st_nxt.resetCnt = RESET_LEN;
        end
      end
    end

    // AXI4-Lite write: address and data accepted in either order
    if (s_axi_awvalid && st_r.awReady) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wReady) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    writeDo = st_nxt.awHeld && st_nxt.wHeld && !st_r.bValid;
    if (writeDo) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = addrMapped(st_nxt.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (st_nxt.wStrb[0] && (st_nxt.awAddr == ADDR_CTRL)) begin
        st_nxt.ctrl = st_nxt.wData[2:0];
      end
      if (st_nxt.wStrb[0] && (st_nxt.awAddr == ADDR_STATUS)) begin
        skewClr = st_nxt.wData[ST_SKEW_SEEN];
      end
    end else if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    st_nxt.awReady = !st_nxt.awHeld && !st_nxt.bValid;
    st_nxt.wReady = !st_nxt.wHeld && !st_nxt.bValid;

    // sticky skew flag; a new fault in the clearing cycle wins
    st_nxt.skewSeen = (st_r.skewSeen && !skewClr) || skewEvent;

    // AXI4-Lite read: one outstanding, data registered with the answer
    if (s_axi_arvalid && st_r.arReady) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rData = regRead(st_r, s_axi_araddr);
      st_nxt.rResp = addrMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    st_nxt.arReady = !st_nxt.rValid;

    // synchronous reset: gate set, counters clear, no pulses
    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.gateFlop = 1'b1;
      st_nxt.ctrl = CTRL_RESET;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // single register for the whole state copy
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // outputs straight from the state flops
  assign testPanelPulse = st_r.testPanel;
  assign dataTransferPulse = st_r.dataXfer;
  assign readSampleStrobe = st_r.strobe;
  assign skewFaultPulse = st_r.skewPulse;
  assign ampResetPulse = st_r.ampReset;
  assign charRatePulse = st_r.charPulse;
  assign s_axi_awready = st_r.awReady;
  assign s_axi_wready = st_r.wReady;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_arready = st_r.arReady;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;
  assign s_axi_rvalid = st_r.rValid;

endmodule : rsgt_read_skew_gate_timing

// [rsgt_chk.sv]
// port-level assertions for the read skew gate timing block
`timescale 1ns/100ps
module rsgt_chk #(
  parameter int SKEW_PULSE_CYCLES = 50000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic combinedChannelPulse,
  input wire logic testPanelPulse,
  input wire logic dataTransferPulse,
  input wire logic readSampleStrobe,
  input wire logic skewFaultPulse,
  input wire logic ampResetPulse,
  input wire logic charRatePulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [12:0] crCnt_r, xferCnt_r;
  logic [15:0] skewCnt_r;
  logic [2:0] upCnt_r;
  // run lengths; crCnt saturates so long idle spells never wrap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crCnt_r <= '1;
      xferCnt_r <= '0;
      skewCnt_r <= '0;
      upCnt_r <= '0;
    end else begin
      crCnt_r <= charRatePulse ? '0 : (&crCnt_r ? crCnt_r : crCnt_r + 13'h1);
      xferCnt_r <= dataTransferPulse ? xferCnt_r + 13'h1 : '0;
      skewCnt_r <= skewFaultPulse ? skewCnt_r + 16'h1 : '0;
      upCnt_r <= (upCnt_r == 3'h4) ? upCnt_r : upCnt_r + 3'h1;
    end
  end
  a_strobe_width: assert property ($rose(readSampleStrobe) |-> ##99 readSampleStrobe ##1 !readSampleStrobe)
    else $error("read strobe width wrong");
  a_amp_width: assert property ($rose(ampResetPulse) |-> ##99 ampResetPulse ##1 !ampResetPulse)
    else $error("amplifier reset width wrong");
  a_xfer_width: assert property ($fell(dataTransferPulse) |-> xferCnt_r inside {[13'd156:13'd157]})
    else $error("transfer pulse not one step long");
  a_skew_width: assert property ($fell(skewFaultPulse) |-> skewCnt_r == SKEW_PULSE_CYCLES)
    else $error("skew pulse width wrong");
  a_skew_at_strobe: assert property ($rose(skewFaultPulse) |-> readSampleStrobe)
    else $error("skew pulse outside strobe time");
  a_strobe_follows: assert property ($rose(readSampleStrobe) |-> $past(dataTransferPulse) || $past(dataTransferPulse, 2))
    else $error("strobe without preceding transfer");
  a_char_spacing: assert property (charRatePulse |-> crCnt_r >= 13'd4990)
    else $error("character rate pulses too close");
  a_char_single: assert property (charRatePulse |=> !charRatePulse)
    else $error("character rate pulse too long");
  a_panel_copy: assert property (upCnt_r == 3'h4 |-> testPanelPulse == $past(combinedChannelPulse, 3))
    else $error("test panel copy wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !(readSampleStrobe || dataTransferPulse || ampResetPulse || skewFaultPulse))
    else $error("pulse during reset");
endmodule : rsgt_chk

// [rsgt_amp_model.sv]
// nine read amplifier channels wire-ORed onto the combined pulse line
`timescale 1ns/100ps
module rsgt_amp_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [26:0] offsets,
  output logic combinedChannelPulse = 1'b0
);
  logic [7:0] t = 8'hff;
  logic [8:0] chan;
  // each channel pulses four clocks at its own offset: in-gate skew gives a ragged blob
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      chan[i] = t >= 8'(offsets[3*i+:3]) && t < 8'(offsets[3*i+:3]) + 8'h4;
    end
  end
  // idle amplifiers leave the shared line pulled low
  always_ff @(posedge clock) begin
    t <= go ? 8'h0 : (t == 8'hff ? t : t + 8'h1);
    combinedChannelPulse <= |chan;
  end
endmodule : rsgt_amp_model

// [rsgt_tb.sv]
// self-checking testbench for the read skew gate timing block
`timescale 1ns/100ps
module tb;
  import rsgt_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, go = 1'b0;
  logic combinedChannelPulse, testPanelPulse, dataTransferPulse, readSampleStrobe;
  logic skewFaultPulse, ampResetPulse, charRatePulse;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'h59842e37;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
  int miscompares = 0, nTests = 0;
  always #10 clock = ~clock;
  rsgt_read_skew_gate_timing #(.SKEW_PULSE_CYCLES(200)) i_dut (.*);
  rsgt_amp_model i_amps (.clock(clock), .go(go), .offsets(seed[26:0]), .combinedChannelPulse(combinedChannelPulse));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // gate length in sub-cell steps; check mode outranks write mode
  function automatic int gate_ticks(input logic [2:0] c);
    return c[1] ? 5 : (c[0] ? 12 : 16);
  endfunction : gate_ticks
  task automatic wrap_up();
    if (miscompares == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded bus wait: a silent slave ends the run instead of hanging
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 100) begin
      miscompares++;
      wrap_up();
    end
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [3:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdreg
  // one character; late adds a straggler just after the gate closes
  task automatic run_char(input logic [2:0] c, input logic late);
    int d = 0, nx = 0, ns = 0, na = 0, nk = 0, nc = 0, g;
    logic px = 1'b0, ps = 1'b0, pa = 1'b0;
    logic [31:0] m;
    g = gate_ticks(c);
    m = late ? 32'hd : 32'h3f000f;
    wr(ADDR_CTRL, {29'h0, c});
    seed = lfsr(seed);
    go <= 1'b1;
    for (int t = 0; t < 8200; t++) begin
      @(posedge clock);
      go <= late && nx == 1 && t == d + 40;
      if (t == 100) begin
        rdreg(ADDR_STATUS);
        chk({30'h0, rd[1:0]}, 32'h0);
      end
      if (dataTransferPulse && !px) begin
        nx++;
        if (nx == 1) d = t;
      end
      ns += int'(readSampleStrobe && !ps);
      na += int'(ampResetPulse && !pa);
      nk += int'(skewFaultPulse);
      nc += int'(charRatePulse);
      px = dataTransferPulse;
      ps = readSampleStrobe;
      pa = ampResetPulse;
    end
    chk({31'h0, d >= (g - 1) * 156 && d <= g * 157 + 170}, 32'h1);
    chk({31'h0, nc > 0}, {31'h0, c[1]});
    chk({31'h0, nk > 0}, {31'h0, late});
    if (!late) begin
      chk(32'(nx), 32'(c[2] ? 2 : 1));
      chk(32'(ns), 32'h1);
      chk(32'(na), 32'h1);
    end
    rdreg(ADDR_STATUS);
    chk(rd & m, {28'h0, late, 3'b011} & m);
    if (late) wr(ADDR_STATUS, 32'h8);
  endtask : run_char
  // reset, register sanity, then every control setting and one skewed character
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h1f0f, 32'h1);
    rdreg(4'hc);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    wr(4'hc, 32'h7);
    chk({30'h0, bs}, {30'h0, RESP_SLVERR});
    wr(ADDR_CTRL, 32'h5);
    chk({30'h0, bs}, {30'h0, RESP_OKAY});
    rdreg(ADDR_CTRL);
    chk(rd, 32'h5);
    for (int i = 0; i < 9; i++) begin
      run_char(i < 8 ? 3'(i) : seed[2:0], i == 8);
    end
    wrap_up();
  end
endmodule : tb
bind rsgt_read_skew_gate_timing rsgt_chk #(.SKEW_PULSE_CYCLES(SKEW_PULSE_CYCLES)) i_chk (.*);
